//--- rtl/edge_detect.sv
// Parameterised rising/falling edge detector producing one-cycle events.
// Assumes levels synchronous to aclk; first cycle after reset only loads.
`timescale 1ns/1ps
module edge_detect #(
	parameter int W = 1,
	parameter bit RISE = 1'b1,
	parameter bit FALL = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic rst,
	// Levels and events
	edge_if.detector e
);
	logic [W-1:0] last_q;
	logic armed_q;

	always_ff @(posedge aclk) begin
		if (rst) begin
			last_q <= '0;
		end else begin
			last_q <= e.level;
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	always_comb begin
		e.event_p = '0;
		if (armed_q) begin
			if (RISE) begin
				e.event_p = e.event_p | (e.level & ~last_q);
			end
			if (FALL) begin
				e.event_p = e.event_p | (~e.level & last_q);
			end
		end
	end
endmodule

//--- rtl/edge_if.sv
// Level in, one-cycle event out, between the controller and its detectors.
// Assumes both sides share one clock.
`timescale 1ns/1ps
interface edge_if #(
	parameter int W = 1
);
	logic [W-1:0] level;
	logic [W-1:0] event_p;

	modport detector (input level, output event_p);
	modport user (output level, input event_p);
endinterface

//--- rtl/sysctl_pkg.sv
// Register map, field positions and reset values of the system controller.
// Assumes a 16-bit AXI4-Lite byte address, one 32-bit word per register.
package sysctl_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [13:0] REG_PIN_IRQ_ENABLE_LOW = 14'h2006;
	localparam logic [13:0] REG_PIN_IRQ_FLAGS_LOW = 14'h2007;
	localparam logic [13:0] REG_MODE_CONTROL = 14'h2015;
	localparam logic [13:0] REG_SYSTEM_STATUS = 14'h2016;
	localparam logic [13:0] REG_PERIPHERAL_INTERRUPT_FLAGS = 14'h2017;
	localparam logic [13:0] REG_PENDING_SOURCE = 14'h2019;
	localparam logic [13:0] REG_PIN_IRQ_ENABLE_HIGH = 14'h2046;
	localparam logic [13:0] REG_PIN_IRQ_FLAGS_HIGH = 14'h2047;
	localparam logic [13:0] REG_SOFTWARE_TRIP = 14'h2061;
	localparam logic [13:0] REG_CORE_SYSTEM_CONTROL = 14'h3fff;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_PIN_IRQ_ENABLE_LOW = 8'h00;
	localparam logic [0:0] RST_PIN_IRQ_ENABLE_HIGH = 1'h0;
	localparam logic [8:0] RST_MODE_CONTROL = 9'h000;
	localparam logic [15:0] RST_CORE_SYSTEM_CONTROL = 16'h0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE_ADC_MUX_LSB = 0;
	localparam int MODE_ADC_CONV = 2;
	localparam int MODE_AUX_PWM = 3;
	localparam int MODE_RECEIVE_PIN_SELECT = 4;
	localparam int MODE_UART = 5;
	localparam int MODE_PWM_UPDATE = 6;
	localparam int MODE_SYNC_IRQ_ENABLE = 7;
	localparam int MODE_TRIP_IRQ_ENABLE = 8;
	localparam int FLAG_SYNC = 0;
	localparam int FLAG_TRIP = 1;
	localparam int SYSCTL_ALT_SERIAL = 10;

	// ----------------------------------------
	// Vector table
	// ----------------------------------------
	localparam logic [15:0] VEC_TABLE_FIRST = 16'h0000;
	localparam logic [15:0] VEC_TABLE_LAST = 16'h002f;
	localparam logic [15:0] VEC_SLOT_WORDS = 16'h0004;
	localparam logic [15:0] VEC_SLOT_TRIP = 16'h0001;
	localparam logic [15:0] VEC_SLOT_SYNC = 16'h0002;
	localparam logic [15:0] VEC_SLOT_PIN = 16'h0003;

	// ----------------------------------------
	// Pending source codes, highest priority first
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_TRIP = 2'b01,
		SRC_SYNC = 2'b10,
		SRC_PIN = 2'b11
	} source_t;

	// ----------------------------------------
	// AXI responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

//--- rtl/sysctl_top.sv
// System controller: peripheral interrupt flags, core interrupt line,
// serial pin steering, mode and status registers on AXI4-Lite.
// Assumes all pin inputs synchronous to aclk and a single clock domain.
//
// Contract
// RQ1: Vector table spans program addresses 0x0000 to 0x002F after reset.
// RQ2: Each source owns one four-word slot in the vector table.
// RQ3: Unmasked interrupts see no latency beyond input synchronisation.
// RQ4: Timer, serial and software interrupts go straight to the core.
// RQ5: Detected peripheral events set their bit in the matching flag register.
// RQ6: Shared core interrupt held low while any peripheral flag is pending.
// RQ7: Software reads the peripheral flag register to find the source.
// RQ8: Simultaneous interrupts: higher-priority source is serviced first.
// RQ9: Reading peripheral flags clears trip and sync bits and acknowledges.
// RQ10: Reading a pin flag register clears all its bits and acknowledges.
// RQ11: Controller enables trip/sync interrupts and drives mux and mode lines.
// RQ12: Read-only status reports trip pin, watchdog and PWM timer state.
// RQ13: Hardware, software or watchdog reset returns all registers to reset.
// RQ14: Mode bit 4 picks receive pin b when set, pin a when clear.
// RQ15: Mode bit 5 joins internal receive data and frame sync (UART).
// RQ16: In UART mode the core output flag drives the frame sync pin.
// RQ17: System control bit 10: receive pin is flag in, transmit is flag out.
// RQ18: Alternate mode: frame syncs become external interrupts zero and one.
// RQ19: Trip raised by trip pin fall, overcurrent or software trip write.
// RQ20: Sync interrupt raised on rising edge of PWM period pulse.
// RQ21: Enabled input pins flag an interrupt on either transition.
// RQ22: Enables and flags reset to zero; a set beats a clearing read.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module sysctl_top #(
	parameter int PINS = 9
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic soft_reset,
	input wire logic watchdog_reset,
	// AXI4-Lite write address and data
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral event sources
	input wire logic pwm_shutdown_input_n,
	input wire logic overcurrent,
	input wire logic pwm_period_pulse,
	input wire logic [PINS-1:0] pin_level,
	input wire logic [PINS-1:0] pin_is_input,
	input wire logic watchdog_state,
	input wire logic pwm_timer_state,
	// Core interrupt side
	output logic peripheral_core_interrupt_n,
	output logic [15:0] pending_vector,
	output logic external_interrupt_zero_n,
	output logic external_interrupt_one_n,
	// Peripheral controls
	output logic [1:0] adc_mux_select,
	output logic adc_conversion_mode,
	output logic aux_pwm_mode,
	output logic pwm_update_mode,
	// Serial pins
	input wire logic receive_pin_a,
	input wire logic receive_pin_b,
	input wire logic receive_frame_sync_i,
	output logic receive_frame_sync_o,
	output logic receive_frame_sync_oe,
	input wire logic transmit_frame_sync_i,
	output logic serial_transmit_data_o,
	// Core serial port side
	output logic serial_receive_data,
	output logic core_receive_frame_sync,
	input wire logic core_receive_frame_sync_o,
	input wire logic core_receive_frame_sync_oe,
	input wire logic core_transmit_data,
	input wire logic core_output_flag,
	output logic flag_input,
	input wire logic flag_output
);
	// ----------------------------------------
	// Reset
	// ----------------------------------------
	logic rst;
	// RQ13 any reset source
	assign rst = ~aresetn | soft_reset | watchdog_reset;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] pin_irq_enable_low_q;
	logic [0:0] pin_irq_enable_high_q;
	logic [8:0] mode_control_q;
	logic [15:0] core_system_control_q;
	logic [1:0] peripheral_interrupt_flags_q;
	logic [1:0] peripheral_interrupt_flags_d;
	logic [7:0] pin_irq_flags_low_q;
	logic [7:0] pin_irq_flags_low_d;
	logic [0:0] pin_irq_flags_high_q;
	logic [0:0] pin_irq_flags_high_d;
	logic software_trip_q;

	// ----------------------------------------
	// Bus state
	// ----------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [13:0] aw_index_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [31:0] wmerge;
	logic wr_hit;
	logic rd_take;
	logic rd_hit;
	logic [31:0] rd_value;
	logic [13:0] rd_index;
	logic clr_periph;
	logic clr_pin_low;
	logic clr_pin_high;

	// ----------------------------------------
	// Edge detectors
	// ----------------------------------------
	edge_if #(.W(1)) trip_e ();
	edge_if #(.W(1)) sync_e ();
	edge_if #(.W(PINS)) pin_e ();

	assign trip_e.level = pwm_shutdown_input_n;
	assign sync_e.level = pwm_period_pulse;
	assign pin_e.level = pin_level;

	// RQ19 trip pin falling edge
	edge_detect #(.W(1), .RISE(1'b0), .FALL(1'b1)) trip_det (
		.aclk(aclk),
		.rst(rst),
		.e(trip_e)
	);

	// RQ20 sync rising edge
	edge_detect #(.W(1), .RISE(1'b1), .FALL(1'b0)) sync_det (
		.aclk(aclk),
		.rst(rst),
		.e(sync_e)
	);

	// RQ21 either pin transition
	edge_detect #(.W(PINS), .RISE(1'b1), .FALL(1'b1)) pin_det (
		.aclk(aclk),
		.rst(rst),
		.e(pin_e)
	);

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
	assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			aw_index_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_index_q <= s_axi_awaddr[15:2];
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			w_have_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sysctl_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? sysctl_pkg::RESP_OKAY
				: sysctl_pkg::RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Byte lanes applied over current contents
	always_comb begin
		wmerge = rd_value_of(aw_index_q);
		for (int i = 0; i < 4; i++) begin
			if (wstrb_q[i]) begin
				wmerge[i*8 +: 8] = wdata_q[i*8 +: 8];
			end
		end
	end

	assign wr_hit = mapped(aw_index_q);

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// RQ22 enables reset to zero
	always_ff @(posedge aclk) begin
		if (rst) begin
			pin_irq_enable_low_q <= sysctl_pkg::RST_PIN_IRQ_ENABLE_LOW;
			pin_irq_enable_high_q <= sysctl_pkg::RST_PIN_IRQ_ENABLE_HIGH;
		end else if (do_write) begin
			if (aw_index_q == sysctl_pkg::REG_PIN_IRQ_ENABLE_LOW) begin
				pin_irq_enable_low_q <= wmerge[7:0];
			end
			if (aw_index_q == sysctl_pkg::REG_PIN_IRQ_ENABLE_HIGH) begin
				pin_irq_enable_high_q <= wmerge[0:0];
			end
		end
	end

	// RQ11 mode and enable bits
	always_ff @(posedge aclk) begin
		if (rst) begin
			mode_control_q <= sysctl_pkg::RST_MODE_CONTROL;
		end else if (do_write &&
			aw_index_q == sysctl_pkg::REG_MODE_CONTROL) begin
			mode_control_q <= wmerge[8:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			core_system_control_q <= sysctl_pkg::RST_CORE_SYSTEM_CONTROL;
		end else if (do_write &&
			aw_index_q == sysctl_pkg::REG_CORE_SYSTEM_CONTROL) begin
			core_system_control_q <= wmerge[15:0];
		end
	end

	// RQ19 software trip write pulse
	always_ff @(posedge aclk) begin
		if (rst) begin
			software_trip_q <= 1'b0;
		end else begin
			software_trip_q <= do_write & wdata_q[0] & wstrb_q[0] &
				(aw_index_q == sysctl_pkg::REG_SOFTWARE_TRIP);
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign rd_index = s_axi_araddr[15:2];
	assign rd_value = rd_value_of(rd_index);

	assign rd_hit = mapped(rd_index);

	always_ff @(posedge aclk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= sysctl_pkg::RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_hit ? rd_value : 32'h0000_0000;
			s_axi_rresp <= rd_hit ? sysctl_pkg::RESP_OKAY
				: sysctl_pkg::RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// RQ9 read of peripheral flags clears
	assign clr_periph = rd_take &
		(rd_index == sysctl_pkg::REG_PERIPHERAL_INTERRUPT_FLAGS);
	// RQ10 read of pin flags clears
	assign clr_pin_low = rd_take &
		(rd_index == sysctl_pkg::REG_PIN_IRQ_FLAGS_LOW);
	assign clr_pin_high = rd_take &
		(rd_index == sysctl_pkg::REG_PIN_IRQ_FLAGS_HIGH);

	// ----------------------------------------
	// Flag registers
	// ----------------------------------------
	// RQ5 set on detection; RQ22 set beats clear
	always_comb begin
		peripheral_interrupt_flags_d = clr_periph ? 2'h0
			: peripheral_interrupt_flags_q;
		if (mode_control_q[sysctl_pkg::MODE_SYNC_IRQ_ENABLE] &&
			sync_e.event_p[0]) begin
			peripheral_interrupt_flags_d[sysctl_pkg::FLAG_SYNC] = 1'b1;
		end
		// RQ19 three trip causes
		if (mode_control_q[sysctl_pkg::MODE_TRIP_IRQ_ENABLE] &&
			(trip_e.event_p[0] || overcurrent || software_trip_q)) begin
			peripheral_interrupt_flags_d[sysctl_pkg::FLAG_TRIP] = 1'b1;
		end
	end

	// RQ21 enabled inputs only
	always_comb begin
		pin_irq_flags_low_d = (clr_pin_low ? 8'h00 : pin_irq_flags_low_q) |
			(pin_e.event_p[7:0] & pin_irq_enable_low_q & pin_is_input[7:0]);
		pin_irq_flags_high_d = (clr_pin_high ? 1'b0 : pin_irq_flags_high_q) |
			(pin_e.event_p[8:8] & pin_irq_enable_high_q & pin_is_input[8:8]);
	end

	// RQ22 flags reset to zero
	always_ff @(posedge aclk) begin
		if (rst) begin
			peripheral_interrupt_flags_q <= '0;
			pin_irq_flags_low_q <= '0;
			pin_irq_flags_high_q <= '0;
		end else begin
			peripheral_interrupt_flags_q <= peripheral_interrupt_flags_d;
			pin_irq_flags_low_q <= pin_irq_flags_low_d;
			pin_irq_flags_high_q <= pin_irq_flags_high_d;
		end
	end

	// ----------------------------------------
	// Core interrupt and priority
	// ----------------------------------------
	sysctl_pkg::source_t pending;

	// RQ3 straight from flags; RQ6 low while pending
	assign peripheral_core_interrupt_n = ~(|peripheral_interrupt_flags_q |
		|pin_irq_flags_low_q | |pin_irq_flags_high_q);

	// RQ8 trip before sync before pins
	always_comb begin
		if (peripheral_interrupt_flags_q[sysctl_pkg::FLAG_TRIP]) begin
			pending = sysctl_pkg::SRC_TRIP;
		end else if (peripheral_interrupt_flags_q[sysctl_pkg::FLAG_SYNC]) begin
			pending = sysctl_pkg::SRC_SYNC;
		end else if (|pin_irq_flags_low_q || |pin_irq_flags_high_q) begin
			pending = sysctl_pkg::SRC_PIN;
		end else begin
			pending = sysctl_pkg::SRC_NONE;
		end
	end

	// RQ1 RQ2 four-word slots within the table
	always_comb begin
		unique case (pending)
			sysctl_pkg::SRC_TRIP: pending_vector = slot_addr(
				sysctl_pkg::VEC_SLOT_TRIP);
			sysctl_pkg::SRC_SYNC: pending_vector = slot_addr(
				sysctl_pkg::VEC_SLOT_SYNC);
			sysctl_pkg::SRC_PIN: pending_vector = slot_addr(
				sysctl_pkg::VEC_SLOT_PIN);
			sysctl_pkg::SRC_NONE: pending_vector = sysctl_pkg::VEC_TABLE_FIRST;
		endcase
	end

	// ----------------------------------------
	// Peripheral controls
	// ----------------------------------------
	// RQ11 mux and mode lines
	assign adc_mux_select = mode_control_q[sysctl_pkg::MODE_ADC_MUX_LSB +: 2];
	assign adc_conversion_mode = mode_control_q[sysctl_pkg::MODE_ADC_CONV];
	assign aux_pwm_mode = mode_control_q[sysctl_pkg::MODE_AUX_PWM];
	assign pwm_update_mode = mode_control_q[sysctl_pkg::MODE_PWM_UPDATE];

	// ----------------------------------------
	// Serial pin steering
	// ----------------------------------------
	logic rx_selected;
	logic uart_mode;
	logic alt_serial;

	// RQ14 receive pin choice
	assign rx_selected =
		mode_control_q[sysctl_pkg::MODE_RECEIVE_PIN_SELECT] ? receive_pin_b
		: receive_pin_a;
	assign uart_mode = mode_control_q[sysctl_pkg::MODE_UART];
	assign alt_serial = core_system_control_q[sysctl_pkg::SYSCTL_ALT_SERIAL];

	// RQ17 receive pin as flag input
	assign flag_input = alt_serial ? rx_selected : 1'b0;
	assign serial_receive_data = alt_serial ? 1'b0 : rx_selected;
	// RQ17 transmit pin as flag output
	assign serial_transmit_data_o = alt_serial ? flag_output
		: core_transmit_data;

	// RQ15 receive data joined to frame sync
	assign core_receive_frame_sync = uart_mode ? rx_selected
		: receive_frame_sync_i;

	// RQ16 core flag onto frame sync pin
	always_comb begin
		if (uart_mode) begin
			receive_frame_sync_o = core_output_flag;
			receive_frame_sync_oe = 1'b1;
		end else if (alt_serial) begin
			receive_frame_sync_o = 1'b0;
			receive_frame_sync_oe = 1'b0;
		end else begin
			receive_frame_sync_o = core_receive_frame_sync_o;
			receive_frame_sync_oe = core_receive_frame_sync_oe;
		end
	end

	// RQ4 RQ18 frame syncs pass straight to core when bit 10 is set, else held high
	assign external_interrupt_zero_n = alt_serial ? receive_frame_sync_i
		: 1'b1;
	assign external_interrupt_one_n = alt_serial ? transmit_frame_sync_i
		: 1'b1;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic mapped(input logic [13:0] idx);
		unique case (idx)
			sysctl_pkg::REG_PIN_IRQ_ENABLE_LOW,
			sysctl_pkg::REG_PIN_IRQ_FLAGS_LOW,
			sysctl_pkg::REG_MODE_CONTROL,
			sysctl_pkg::REG_SYSTEM_STATUS,
			sysctl_pkg::REG_PERIPHERAL_INTERRUPT_FLAGS,
			sysctl_pkg::REG_PENDING_SOURCE,
			sysctl_pkg::REG_PIN_IRQ_ENABLE_HIGH,
			sysctl_pkg::REG_PIN_IRQ_FLAGS_HIGH,
			sysctl_pkg::REG_SOFTWARE_TRIP,
			sysctl_pkg::REG_CORE_SYSTEM_CONTROL: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] slot_addr(input logic [15:0] slot);
		logic [15:0] a;
		a = 16'(slot * sysctl_pkg::VEC_SLOT_WORDS);
		if (a > sysctl_pkg::VEC_TABLE_LAST) begin
			a = sysctl_pkg::VEC_TABLE_FIRST;
		end
		return a;
	endfunction

	// RQ12 read-only status
	function automatic logic [31:0] rd_value_of(input logic [13:0] idx);
		logic [31:0] v;
		v = '0;
		unique case (idx)
			sysctl_pkg::REG_PIN_IRQ_ENABLE_LOW: v[7:0] = pin_irq_enable_low_q;
			sysctl_pkg::REG_PIN_IRQ_FLAGS_LOW: v[7:0] = pin_irq_flags_low_q;
			sysctl_pkg::REG_MODE_CONTROL: v[8:0] = mode_control_q;
			sysctl_pkg::REG_SYSTEM_STATUS: v[3:0] = {
				~peripheral_core_interrupt_n, pwm_timer_state,
				watchdog_state, pwm_shutdown_input_n};
			sysctl_pkg::REG_PERIPHERAL_INTERRUPT_FLAGS:
				v[1:0] = peripheral_interrupt_flags_q;
			sysctl_pkg::REG_PENDING_SOURCE: v[1:0] = pending;
			sysctl_pkg::REG_PIN_IRQ_ENABLE_HIGH: v[0:0] = pin_irq_enable_high_q;
			sysctl_pkg::REG_PIN_IRQ_FLAGS_HIGH: v[0:0] = pin_irq_flags_high_q;
			sysctl_pkg::REG_CORE_SYSTEM_CONTROL: v[15:0] = core_system_control_q;
			default: v = '0;
		endcase
		return v;
	endfunction
endmodule

//--- test/core_model.sv
// Core model: serial and flag outputs of the core.
// Assumes pins change just after each aclk edge.
`timescale 1ns/1ps
module core_model (
	// Clock
	input wire logic aclk,
	// Core pins
	output logic core_output_flag,
	output logic core_transmit_data,
	output logic flag_output,
	output logic core_receive_frame_sync_o,
	output logic core_receive_frame_sync_oe
);
	logic [4:0] cnt_q = 5'h00;
	// Toggles so stale paths show
	always_ff @(posedge aclk) begin
		cnt_q <= cnt_q + 5'h07;
	end
	assign {core_receive_frame_sync_oe, core_receive_frame_sync_o,
		flag_output, core_transmit_data, core_output_flag} = cnt_q;
endmodule

//--- test/peripheral_irq_and_serial_mux_bench.sv
// Bench: register bus, peripheral flags, core line, serial steering.
// Assumes sysctl_top, its checker and the core model compiled first.
`timescale 1ns/1ps
module peripheral_irq_and_serial_mux_bench;
	logic aclk = '0, aresetn = '0, soft_reset = '0, watchdog_reset = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0, pending_vector;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, e, t, m;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, adc_mux_select;
	wire logic [3:0] s_axi_wstrb = 4'hf;
	logic pwm_shutdown_input_n = 1'h1, overcurrent = '0, pwm_period_pulse = '0;
	logic watchdog_state = '0, pwm_timer_state = '0, rfs_ext = '0;
	logic receive_pin_a = '0, receive_pin_b = '0, transmit_frame_sync_i = '0;
	logic [8:0] pin_level = '0, pin_is_input = '0;
	logic peripheral_core_interrupt_n, external_interrupt_zero_n;
	logic external_interrupt_one_n, adc_conversion_mode, aux_pwm_mode;
	logic pwm_update_mode, receive_frame_sync_o, receive_frame_sync_oe;
	logic serial_transmit_data_o, serial_receive_data, core_receive_frame_sync;
	logic flag_input, core_receive_frame_sync_o, core_receive_frame_sync_oe;
	logic core_transmit_data, core_output_flag, flag_output;
	logic [3:0] k;
	int errors = 0, samples_checked = 0, cyc = 0;
	// Frame sync pin level from both drivers
	wire logic receive_frame_sync_i =
		receive_frame_sync_oe ? receive_frame_sync_o : rfs_ext;
	sysctl_top i_sysctl_top (.*);
	core_model i_core_model (.*);
	initial forever #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	task give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, g, x);
		end
	endtask
	task wr(input logic [13:0] i, input logic [31:0] x);
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= x;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		cmp(s_axi_bresp, 2'h0);
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [13:0] i);
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'h0;
	endtask
	task rc(input logic [13:0] i, input logic [31:0] x);
		rd(i);
		cmp(d, x);
	endtask
	function automatic logic [5:0] steer(input logic [1:0] md, input logic alt);
		logic s;
		s = md[0] ? receive_pin_b : receive_pin_a;
		return {!alt & s, alt & s, alt ? flag_output : core_transmit_data,
			!alt | receive_frame_sync_i, !alt | transmit_frame_sync_i,
			md[1] ? s : receive_frame_sync_i};
	endfunction
	initial begin
		void'($urandom(25387));
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		rc(14'h3fff, 32'h0);
		rc(14'h2006, 32'h0);
		rd(14'h2014);
		cmp(r, 2'h3);
		for (k = 4'h0; k < 4'h2; k++) begin
			m = $urandom & 32'h1ff;
			wr(14'h2015, m);
			rc(14'h2015, m);
			cmp({adc_mux_select, adc_conversion_mode, aux_pwm_mode,
				pwm_update_mode}, {m[1:0], m[2], m[3], m[6]});
			{soft_reset, watchdog_reset} <= k[0] ? 2'h1 : 2'h2;
			@(posedge aclk);
			{soft_reset, watchdog_reset} <= 2'h0;
			rc(14'h2015, 32'h0);
		end
		$display("test reset done");
		wr(14'h2015, 32'h180);
		for (k = 4'h0; k < 4'h5; k++) begin
			@(posedge aclk);
			case (k)
			4'h0: pwm_shutdown_input_n <= 1'h0;
			4'h1: overcurrent <= 1'h1;
			4'h2: wr(14'h2061, 32'h1);
			default: {pwm_shutdown_input_n, pwm_period_pulse} <= {!k[0], 1'h1};
			endcase
			repeat (3) @(posedge aclk);
			{pwm_shutdown_input_n, overcurrent, pwm_period_pulse} <= 3'h4;
			#1 cmp(pending_vector, k == 4'h4 ? 16'h8 : 16'h4);
			rc(14'h2017, k == 4'h3 ? 2'h3 : k == 4'h4 ? 2'h1 : 2'h2);
			#1 cmp(peripheral_core_interrupt_n, 1'h1);
		end
		$display("test trip done");
		for (k = 4'h0; k < 4'h4; k++) begin
			e = $urandom | 32'h1;
			m = $urandom | 32'h1;
			t = $urandom | 32'h1;
			wr(14'h2006, e & 32'hff);
			wr(14'h2046, e >> 8 & 32'h1);
			pin_is_input <= m[8:0];
			@(posedge aclk);
			pin_level <= pin_level ^ t[8:0];
			repeat (3) @(posedge aclk);
			t = t & e & m & 32'h1ff;
			#1 cmp(pending_vector, t != 0 ? 16'hc : 16'h0);
			rc(14'h2007, t & 32'hff);
			rc(14'h2047, t >> 8);
			#1 cmp(peripheral_core_interrupt_n, 1'h1);
		end
		$display("test pins done");
		{watchdog_state, pwm_timer_state} <= 2'($urandom);
		@(posedge aclk);
		rc(14'h2016, {pwm_timer_state, watchdog_state, 1'h1});
		$display("test status done");
		for (k = 4'h0; k < 4'h8; k++) begin
			wr(14'h2015, {k[1:0], 4'h0});
			wr(14'h3fff, {k[2], 10'h0});
			m = $urandom;
			{receive_pin_a, receive_pin_b, rfs_ext, transmit_frame_sync_i} <= m[3:0];
			@(posedge aclk);
			#1 t = {serial_receive_data, flag_input, serial_transmit_data_o,
				external_interrupt_zero_n, external_interrupt_one_n,
				core_receive_frame_sync};
			cmp(t, steer(k[1:0], k[2]));
		end
		$display("test serial done");
		give_verdict();
	end
endmodule

//--- test/sysctl_props.sv
// Checker on the system controller ports.
// Assumes one aclk domain; bound to sysctl_top.
`timescale 1ns/1ps
module sysctl_props (
	// Clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic soft_reset,
	input wire logic watchdog_reset,
	// Bus and interrupts
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic peripheral_core_interrupt_n,
	input wire logic [15:0] pending_vector,
	input wire logic external_interrupt_zero_n,
	input wire logic external_interrupt_one_n,
	// Serial pins
	input wire logic receive_frame_sync_i,
	input wire logic receive_frame_sync_o,
	input wire logic receive_frame_sync_oe,
	input wire logic core_receive_frame_sync_oe,
	input wire logic core_output_flag,
	input wire logic serial_transmit_data_o,
	input wire logic serial_receive_data,
	input wire logic flag_output,
	input wire logic flag_input,
	input wire logic receive_pin_a,
	input wire logic receive_pin_b
);
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || soft_reset || watchdog_reset);
	chk_line_pending: assert property (
		peripheral_core_interrupt_n == (pending_vector == 16'h0000))
		else $error("line and vector differ");
	chk_line_holds: assert property (
		!peripheral_core_interrupt_n && !ar_hs |=> !peripheral_core_interrupt_n)
		else $error("line freed early");
	chk_ack_read: assert property (
		$rose(peripheral_core_interrupt_n) |-> $past(ar_hs))
		else $error("line rose without read");
	chk_trip_first: assert property (
		pending_vector == 16'h0004 && !ar_hs |=> pending_vector == 16'h0004)
		else $error("trip slot lost");
	chk_reset_idle: assert property (
		$past(!aresetn) |-> peripheral_core_interrupt_n)
		else $error("line low after reset");
	chk_alt_steer: assert property (
		!external_interrupt_zero_n |->
		serial_transmit_data_o == flag_output && !serial_receive_data)
		else $error("alt steering wrong");
	chk_ext_pass: assert property (
		!external_interrupt_one_n |->
		external_interrupt_zero_n == receive_frame_sync_i)
		else $error("frame sync not passed");
	chk_flag_in: assert property (
		flag_input |-> (receive_pin_a || receive_pin_b) && !serial_receive_data)
		else $error("flag input wrong");
	chk_uart_drive: assert property (
		receive_frame_sync_oe && !core_receive_frame_sync_oe |->
		receive_frame_sync_o == core_output_flag)
		else $error("frame sync drive wrong");
	cover property (pending_vector == 16'h0004);
	cover property (pending_vector == 16'h000c);
	cover property (!external_interrupt_zero_n);
endmodule

bind sysctl_top sysctl_props i_sysctl_props (.*);
